// *** hw/radio_path_ctrl.sv ***
// receive and transmit path sequencer with its apb register file
// Overview of operation
// - R2 bit 11 picks injection: high places LO 6.0 MHz above, low below.
// - Receive: mixer enabled about 150 us after the enable pin rises.
// - Receive: post-mixer stage enabled about 10 us after the enable pin rises.
// - Receive: filter enabled at 10 us, its tuning done at 140 us.
// - Pin falling disables receive stages at once; off in idle and transmit.
// - Filter recalibrates every receive cycle against an internal 6.0 MHz reference.
// - 4-bit strength readable in R29 bits 3-0 in idle when both enables set.
// - Strength updates about 40 us after the word marker reference point.
// - Demodulated samples are 6-bit two's complement at about 2.08 Msamples/s.
// - Samples leave as a serial two's complement bit stream.
// - A word marker flags the first bit of every 6-bit sample.
// - A bit clock output accompanies the serial data.
// - Each transmit cycle trims the VCO before power stages enable.
// - R5 bits 2-0 select one of eight output power levels.
// - Output power ramps exponentially up and down, settling within 20 us.
// - General output pin follows R2 bit 8.
// - External amplifier enable is off while R11 bit 6 and R3 bit 10 are both clear.
// - Receive: low-noise stage enabled about 150 us after the pin rises.
// - R3 bit 6 set inverts the general output pin; resets to zero.
// - R3 bit 10 set drives amplifier enable as inverse of general output.
`timescale 1ns/1ps
`default_nettype none
module radio_path_ctrl
  import radio_path_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     radio_cycle_enable_pin,
  input  wire logic [SAMPLE_W-1:0]      demodSample,
  input  wire logic [STRENGTH_W-1:0]    strengthCode,
  output logic                          lnaEnable,
  output logic                          mixerEnable,
  output logic                          post_mixer_gain_stage,
  output logic                          filterEnable,
  output logic                          filterCalRefEnable,
  output logic                          filterTuned,
  output logic                          injectHighSide,
  output logic signed [15:0]            loOffsetKhz,
  output logic                          vcoTrimActive,
  output logic                          low_power_output_stage,
  output logic      [LEVEL_W-1:0]       output_power_level_field,
  output logic      [RAMP_W-1:0]        rampLevel,
  output logic                          serialData,
  output logic                          serialClock,
  output logic                          sample_word_marker,
  output logic                          general_output_pin,
  output logic                          ext_amp_enable_out
);
  path_if link ();

  logic [REG_W-1:0]      r2_q, r3_q, r4_q, r5_q, r9_q, r11_q, mode_q;
  logic [STRENGTH_W-1:0] strength_q;
  logic                  pinMeta_q, pinSync_q;
  logic [CNT_W-1:0]      time_q;
  cycle_t                cyc_q, cyc_d;
  logic                  setup, access, wrStrobe, mapped;
  logic [7:0]            idx;

  sample_serializer u_ser (.sys_clk(sys_clk), .srst(srst), .link(link));
  power_ramp        u_ramp(.sys_clk(sys_clk), .srst(srst), .link(link));

  // ---------------- apb slave, zero wait states ----------------
  function automatic logic isMapped(input logic [7:0] i);
    isMapped = (i == IDX_R2) || (i == IDX_R3) || (i == IDX_R4) || (i == IDX_R5) ||
               (i == IDX_R9) || (i == IDX_R11) || (i == IDX_R29) ||
               (i == IDX_MODE) || (i == IDX_STATUS);
  endfunction

  assign idx      = paddr[9:2];
  assign mapped   = isMapped(idx) && (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wrStrobe = access && pwrite && mapped;
  assign pready   = 1'b1;
  assign pslverr  = access && !mapped;

  // register writes land only on the access edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r2_q   <= REG_RESET;
      r3_q   <= REG_RESET;
      r4_q   <= REG_RESET;
      r5_q   <= REG_RESET;
      r9_q   <= REG_RESET;
      r11_q  <= REG_RESET;
      mode_q <= REG_RESET;
    end else if (wrStrobe) begin
      unique case (idx)
        IDX_R2:   r2_q   <= pwdata[REG_W-1:0];
        IDX_R3:   r3_q   <= pwdata[REG_W-1:0];
        IDX_R4:   r4_q   <= pwdata[REG_W-1:0];
        IDX_R5:   r5_q   <= pwdata[REG_W-1:0];
        IDX_R9:   r9_q   <= pwdata[REG_W-1:0];
        IDX_R11:  r11_q  <= pwdata[REG_W-1:0];
        IDX_MODE: mode_q <= pwdata[REG_W-1:0];
        default:  ;  // read-only words ignore writes
      endcase
    end
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= '0;
      if (mapped) begin
        unique case (idx)
          IDX_R2:     prdata <= 32'(r2_q);
          IDX_R3:     prdata <= 32'(r3_q);
          IDX_R4:     prdata <= 32'(r4_q);
          IDX_R5:     prdata <= 32'(r5_q);
          IDX_R9:     prdata <= 32'(r9_q);
          IDX_R11:    prdata <= 32'(r11_q);
          IDX_MODE:   prdata <= 32'(mode_q);
          IDX_STATUS: prdata <= 32'({filterTuned, vcoTrimActive, cyc_q});
          IDX_R29:    prdata <= (cyc_q == CYC_IDLE && r4_q[SS_EN_BIT] && r9_q[SS_RD_BIT])
                                ? 32'(strength_q) : '0;
          default:    prdata <= '0;
        endcase
      end
    end
  end

  // ---------------- enable pin synchroniser ----------------
  // first stage feeds only the second; the pin is asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
    end else begin
      pinMeta_q <= radio_cycle_enable_pin;
      pinSync_q <= pinMeta_q;
    end
  end

  // ---------------- cycle sequencer ----------------
  always_comb begin
    cyc_d = cyc_q;
    unique case (cyc_q)
      CYC_IDLE:    if (pinSync_q) cyc_d = mode_q[MODE_TX_BIT] ? CYC_TX_TRIM : CYC_RX;
      CYC_RX:      if (!pinSync_q) cyc_d = CYC_IDLE;
      CYC_TX_TRIM: if (!pinSync_q) cyc_d = CYC_TX_DOWN;
                   else if (time_q == CNT_W'(VCO_TRIM_CYC)) cyc_d = CYC_TX_ON;
      CYC_TX_ON:   if (!pinSync_q) cyc_d = CYC_TX_DOWN;
      CYC_TX_DOWN: if (link.rampAtZero) cyc_d = CYC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cyc_q <= CYC_IDLE;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  // elapsed time since the cycle last changed state; saturates so late stages stay on
  always_ff @(posedge sys_clk) begin
    if (srst || cyc_d != cyc_q) begin
      time_q <= '0;
    end else if (time_q != '1) begin
      time_q <= time_q + CNT_W'(1);
    end
  end

  // receive stage enables; all drop as soon as the cycle leaves receive
  // the entry edge still sees the stale idle count, so it must not arm any stage
  always_ff @(posedge sys_clk) begin
    if (srst || cyc_d != CYC_RX || cyc_q != CYC_RX) begin
      lnaEnable             <= 1'b0;
      mixerEnable           <= 1'b0;
      post_mixer_gain_stage <= 1'b0;
      filterEnable          <= 1'b0;
      filterCalRefEnable    <= 1'b0;
      filterTuned           <= 1'b0;
    end else begin
      post_mixer_gain_stage <= time_q >= CNT_W'(EARLY_STAGE_CYC - 1);
      filterEnable          <= time_q >= CNT_W'(EARLY_STAGE_CYC - 1);
      filterCalRefEnable    <= time_q >= CNT_W'(EARLY_STAGE_CYC - 1) &&
                               time_q <  CNT_W'(FILTER_TUNED_CYC - 1);
      filterTuned           <= time_q >= CNT_W'(FILTER_TUNED_CYC - 1);
      mixerEnable           <= time_q >= CNT_W'(LATE_STAGE_CYC - 1);
      lnaEnable             <= time_q >= CNT_W'(LATE_STAGE_CYC - 1);
    end
  end

  // the first word marker after tuning is the reference point for the update
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      strength_q <= '0;
    end else if (cyc_q == CYC_RX && r4_q[SS_EN_BIT] &&
                 time_q == CNT_W'(STRENGTH_UPD_CYC)) begin
      strength_q <= strengthCode;
    end
  end

  // serial stream runs only once the filter is tuned
  assign link.serEnable = filterTuned;
  assign link.sample    = demodSample;
  assign link.powerOn   = (cyc_q == CYC_TX_ON);
  assign serialData         = link.serialData;
  assign serialClock        = link.serialClock;
  assign sample_word_marker = link.wordMarker;
  assign rampLevel          = link.rampLevel;

  // ---------------- transmit and pin outputs ----------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vcoTrimActive            <= 1'b0;
      low_power_output_stage   <= 1'b0;
      output_power_level_field <= '0;
      injectHighSide           <= 1'b0;
      loOffsetKhz              <= '0;
      general_output_pin       <= 1'b0;
      ext_amp_enable_out       <= 1'b0;
    end else begin
      vcoTrimActive            <= (cyc_d == CYC_TX_TRIM);
      // power stage stays on through ramp down so the ramp ends at zero
      low_power_output_stage   <= (cyc_d == CYC_TX_ON) ||
                                  (cyc_d == CYC_TX_DOWN);
      output_power_level_field <= r5_q[LEVEL_W-1:0];
      injectHighSide           <= r2_q[INJ_HIGH_BIT];
      loOffsetKhz              <= r2_q[INJ_HIGH_BIT] ? LO_OFFSET_KHZ : -LO_OFFSET_KHZ;
      general_output_pin       <= r2_q[GEN_OUT_BIT] ^ r3_q[GEN_POL_BIT];
      if (r3_q[EXT_INV_BIT]) begin
        ext_amp_enable_out <= ~(r2_q[GEN_OUT_BIT] ^ r3_q[GEN_POL_BIT]);
      end else begin
        ext_amp_enable_out <= r11_q[EXT_EN_BIT] &&
                              (cyc_d == CYC_TX_ON || cyc_d == CYC_TX_DOWN);
      end
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence rxStart;
    cyc_q == CYC_IDLE && pinSync_q && !mode_q[MODE_TX_BIT];
  endsequence
  sequence pinHeld(int n);
    pinSync_q [*1];
  endsequence

  rx_early_stage_a: assert property (
    cyc_q == CYC_RX && pinSync_q && time_q == CNT_W'(EARLY_STAGE_CYC - 1) |=>
      post_mixer_gain_stage && filterEnable && !mixerEnable)
    else $error("early receive stages not on at their delay");
  rx_late_stage_a: assert property (
    cyc_q == CYC_RX && time_q == CNT_W'(LATE_STAGE_CYC - 2) ##1 cyc_q == CYC_RX && pinSync_q |->
      !mixerEnable ##1 (mixerEnable && lnaEnable))
    else $error("mixer or low-noise stage off at late delay");
  rx_tuned_a: assert property (
    $rose(filterTuned) |-> cyc_q == CYC_RX && time_q == CNT_W'(FILTER_TUNED_CYC))
    else $error("filter tuned at wrong time");
  rx_drop_a: assert property (
    cyc_q == CYC_RX && !pinSync_q |=>
      !lnaEnable && !mixerEnable && !post_mixer_gain_stage && !filterEnable)
    else $error("receive stages not dropped with the pin");
  rx_cal_a: assert property (
    rxStart ##1 pinSync_q [*8] |-> filterCalRefEnable == 1'b0)
    else $error("calibration reference on too early");
  tx_trim_order_a: assert property (
    $rose(low_power_output_stage) |-> $past(vcoTrimActive))
    else $error("power stage enabled without trim");
  gen_out_a: assert property (
    ##1 general_output_pin == $past(r2_q[GEN_OUT_BIT] ^ r3_q[GEN_POL_BIT]))
    else $error("general output does not follow its bit");
  ext_amp_off_a: assert property (
    !r11_q[EXT_EN_BIT] && !r3_q[EXT_INV_BIT] ##1 !r11_q[EXT_EN_BIT] && !r3_q[EXT_INV_BIT]
      |-> !ext_amp_enable_out)
    else $error("amplifier enable high while disabled");
  ext_amp_inv_a: assert property (
    r3_q[EXT_INV_BIT] ##1 $stable(r2_q) && $stable(r3_q) |->
      ext_amp_enable_out == !general_output_pin)
    else $error("amplifier enable not complement of general output");
  strength_read_a: assert property (
    setup && idx == IDX_R29 && !(r4_q[SS_EN_BIT] && r9_q[SS_RD_BIT]) |=> prdata == '0)
    else $error("strength readable without both enables");
  marker_bit_a: assert property (
    $rose(sample_word_marker) |-> serialData == $past(demodSample[SAMPLE_W-1]))
    else $error("marker not on the sample msb");
endmodule
`default_nettype wire

// *** inc/radio_path_pkg.sv ***
// constants, register map and types for the radio receive/transmit path control
package radio_path_pkg;
  // clock and timing figures
  localparam int SYS_CLK_MHZ      = 25;
  localparam int EARLY_STAGE_US   = 10;   // post-mixer stage and filter turn-on
  localparam int FILTER_TUNED_US  = 140;  // filter tuning complete
  localparam int LATE_STAGE_US    = 150;  // mixer and low-noise stage turn-on
  localparam int STRENGTH_UPD_US  = 40;   // after the word marker reference point
  localparam int VCO_TRIM_US      = 40;   // transmit trim window before power stages
  localparam int RAMP_SETTLE_US   = 20;   // longest ramp settling time
  localparam int EARLY_STAGE_CYC  = EARLY_STAGE_US * SYS_CLK_MHZ;
  localparam int FILTER_TUNED_CYC = FILTER_TUNED_US * SYS_CLK_MHZ;
  localparam int LATE_STAGE_CYC   = LATE_STAGE_US * SYS_CLK_MHZ;
  localparam int STRENGTH_UPD_CYC = FILTER_TUNED_CYC + STRENGTH_UPD_US * SYS_CLK_MHZ;
  localparam int VCO_TRIM_CYC     = VCO_TRIM_US * SYS_CLK_MHZ;
  localparam int RAMP_SETTLE_CYC  = RAMP_SETTLE_US * SYS_CLK_MHZ;
  localparam int RAMP_MAX_STEPS   = 48;
  localparam int RAMP_STEP_CYC    = RAMP_SETTLE_CYC / RAMP_MAX_STEPS;
  localparam int CNT_W            = 13;
  // data widths
  localparam int SAMPLE_W   = 6;
  localparam int STRENGTH_W = 4;
  localparam int LEVEL_W    = 3;
  localparam int RAMP_W     = 8;
  localparam int RAMP_SHIFT = 3;
  localparam int REG_W      = 16;
  localparam int BIT_CYC    = 2;          // sys_clk cycles per serial bit
  localparam logic signed [15:0] LO_OFFSET_KHZ = 16'sh1770;  // 6.0 MHz
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_R2     = 8'h02;
  localparam logic [7:0] IDX_R3     = 8'h03;
  localparam logic [7:0] IDX_R4     = 8'h04;
  localparam logic [7:0] IDX_R5     = 8'h05;
  localparam logic [7:0] IDX_R9     = 8'h09;
  localparam logic [7:0] IDX_R11    = 8'h0b;
  localparam logic [7:0] IDX_R29    = 8'h1d;
  localparam logic [7:0] IDX_MODE   = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  // field positions
  localparam int INJ_HIGH_BIT = 11;  // R2
  localparam int GEN_OUT_BIT  = 8;   // R2
  localparam int GEN_POL_BIT  = 6;   // R3
  localparam int EXT_INV_BIT  = 10;  // R3
  localparam int SS_EN_BIT    = 6;   // R4
  localparam int SS_RD_BIT    = 8;   // R9
  localparam int EXT_EN_BIT   = 6;   // R11
  localparam int MODE_TX_BIT  = 0;   // mode register
  typedef enum logic [2:0] {CYC_IDLE, CYC_RX, CYC_TX_TRIM, CYC_TX_ON, CYC_TX_DOWN} cycle_t;
endpackage

// *** inc/path_if.sv ***
// carrier between the sequencer and its serializer and ramp helpers
`timescale 1ns/1ps
`default_nettype none
interface path_if;
  import radio_path_pkg::*;
  logic                  serEnable;
  logic [SAMPLE_W-1:0]   sample;
  logic                  serialData;
  logic                  serialClock;
  logic                  wordMarker;
  logic                  powerOn;
  logic [RAMP_W-1:0]     rampLevel;
  logic                  rampAtZero;
  modport seq  (output serEnable, sample, powerOn,
                input serialData, serialClock, wordMarker, rampLevel, rampAtZero);
  modport ser  (input serEnable, sample, output serialData, serialClock, wordMarker);
  modport ramp (input powerOn, output rampLevel, rampAtZero);
endinterface
`default_nettype wire

// *** hw/sample_serializer.sv ***
// shifts demodulated samples out msb first with a word marker and bit clock
`timescale 1ns/1ps
`default_nettype none
module sample_serializer
  import radio_path_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  path_if.ser       link
);
  logic [SAMPLE_W-1:0] shift_q;
  logic [2:0]          bitIdx_q;
  logic                phase_q;

  // two sys_clk cycles per bit so the bit clock has a real high and low half
  always_ff @(posedge sys_clk) begin
    if (srst || !link.serEnable) begin
      shift_q  <= '0;
      bitIdx_q <= '0;
      phase_q  <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      if (!phase_q && bitIdx_q == 3'd0) begin
        shift_q <= link.sample;
      end else if (phase_q) begin
        shift_q  <= {shift_q[SAMPLE_W-2:0], 1'b0};
        bitIdx_q <= (bitIdx_q == 3'(SAMPLE_W - 1)) ? 3'd0 : bitIdx_q + 3'd1;
      end
    end
  end

  // outputs from flops: data changes with clock low, receiver samples on rise
  always_ff @(posedge sys_clk) begin
    if (srst || !link.serEnable) begin
      link.serialData  <= 1'b0;
      link.serialClock <= 1'b0;
      link.wordMarker  <= 1'b0;
    end else begin
      link.serialClock <= phase_q;
      if (!phase_q) begin
        link.serialData <= (bitIdx_q == 3'd0) ? link.sample[SAMPLE_W-1]
                                              : shift_q[SAMPLE_W-1];
        link.wordMarker <= (bitIdx_q == 3'd0);
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/power_ramp.sv ***
// exponential ramp of transmit output power toward full scale or zero
`timescale 1ns/1ps
`default_nettype none
module power_ramp
  import radio_path_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  path_if.ramp      link
);
  logic [RAMP_W-1:0] level_q;
  logic [5:0]        tick_q;

  // close an eighth of the remaining gap, then snap when the gap is small
  function automatic logic [RAMP_W-1:0] rampNext(input logic [RAMP_W-1:0] cur,
                                                 input logic             up);
    logic [RAMP_W-1:0] gap;
    gap = up ? ~cur : cur;
    if (gap < RAMP_W'(1 << RAMP_SHIFT)) begin
      rampNext = up ? '1 : '0;
    end else if (up) begin
      rampNext = cur + (gap >> RAMP_SHIFT);
    end else begin
      rampNext = cur - (gap >> RAMP_SHIFT);
    end
  endfunction

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick_q <= '0;
    end else begin
      tick_q <= (tick_q == 6'(RAMP_STEP_CYC - 1)) ? '0 : tick_q + 6'd1;
    end
  end

  // settles within the step budget from either end of the scale
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      level_q <= '0;
    end else if (tick_q == '0) begin
      level_q <= rampNext(level_q, link.powerOn);
    end
  end

  assign link.rampLevel  = level_q;
  assign link.rampAtZero = (level_q == '0);
endmodule
`default_nettype wire

// *** tb/baseband_rx_model.sv ***
// baseband receiver model: takes serial samples on each bit clock rise
`timescale 1ns/1ps
`default_nettype none
module baseband_rx_model
  import radio_path_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic                serialData,
  input  wire logic                serialClock,
  input  wire logic                sample_word_marker,
  output logic      [SAMPLE_W-1:0] lastWord,
  output logic      [15:0]         wordCount
);
  logic                clkSeen;
  logic [SAMPLE_W-2:0] shiftReg;
  logic [2:0]          bitCount;
  // bit clock is oversampled by sys_clk, so a rise is a low-then-high pair
  always_ff @(posedge sys_clk) begin
    clkSeen <= serialClock;
    if (srst) begin
      bitCount  <= 3'h0;
      wordCount <= 16'h0000;
    end else if (serialClock && !clkSeen && (sample_word_marker || bitCount != 3'h0)) begin
      // the marker restarts the word, so one slip cannot skew later words
      shiftReg <= {shiftReg[SAMPLE_W-3:0], serialData};
      bitCount <= sample_word_marker ? 3'h1 : bitCount + 3'h1;
      if (!sample_word_marker && bitCount == 3'h5) begin
        lastWord  <= {shiftReg, serialData};
        wordCount <= wordCount + 16'h0001;
        bitCount  <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/radio_path_ctrl_tb_top.sv ***
// self-checking bench for the radio path sequencer
`timescale 1ns/1ps
`default_nettype none
module radio_path_ctrl_tb_top;
  import radio_path_pkg::*;
  logic                  sys_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [SAMPLE_W-1:0]   demodSample, lastWord;
  logic [STRENGTH_W-1:0] strengthCode;
  logic                  radio_cycle_enable_pin, lnaEnable, mixerEnable, post_mixer_gain_stage;
  logic                  filterEnable, filterCalRefEnable, filterTuned, injectHighSide;
  logic                  vcoTrimActive, low_power_output_stage, serialData, serialClock;
  logic                  sample_word_marker, general_output_pin, ext_amp_enable_out;
  logic signed [15:0]    loOffsetKhz;
  logic [LEVEL_W-1:0]    output_power_level_field;
  logic [RAMP_W-1:0]     rampLevel, rampHold;
  logic [15:0]           wordCount;
  logic [5:0]            probe;
  int                    numErrors, checked, a;
  // stage flags gathered so one bounded wait serves every timing check
  assign probe = {low_power_output_stage, vcoTrimActive, mixerEnable, filterTuned,
                  post_mixer_gain_stage, lnaEnable};
  // system clock, 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  radio_path_ctrl u_radio_path_ctrl (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .radio_cycle_enable_pin, .demodSample, .strengthCode, .lnaEnable,
    .mixerEnable, .post_mixer_gain_stage, .filterEnable, .filterCalRefEnable, .filterTuned,
    .injectHighSide, .loOffsetKhz, .vcoTrimActive, .low_power_output_stage,
    .output_power_level_field, .rampLevel, .serialData, .serialClock, .sample_word_marker,
    .general_output_pin, .ext_amp_enable_out);
  baseband_rx_model u_baseband_rx_model (.sys_clk, .srst, .serialData, .serialClock,
    .sample_word_marker, .lastWord, .wordCount);
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts falling edges until probe bit idx shows lvl; overrun ends the run
  task automatic waitFor(input int idx, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (probe[idx] !== lvl) begin
      @(negedge sys_clk);
      cnt++;
      if (cnt > bound) begin
        numErrors++;
        wrap_up();
      end
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (k > 16) begin
        numErrors++;
        wrap_up();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset values, unmapped access, injection side
  task automatic t_regs();
    apb(1'b0, IDX_R3, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h3f, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, IDX_R2, 32'h800);
    repeat (3) @(negedge sys_clk);
    chk({16'h0000, loOffsetKhz}, 32'h1770);
    apb(1'b1, IDX_R2, 32'h0);
    repeat (3) @(negedge sys_clk);
    chk({31'h0, injectHighSide}, 32'h0);
    chk({16'h0000, loOffsetKhz}, 32'he890);
    $display("registers done");
  endtask
  // every polarity combination and every power level code
  task automatic t_outputs();
    logic [3:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[3:0];
      apb(1'b1, IDX_R2, {23'h0, c[0], 8'h00});
      apb(1'b1, IDX_R3, {21'h0, c[2], 3'h0, c[1], 6'h00});
      apb(1'b1, IDX_R5, {29'h0, c[2:0]});
      repeat (3) @(negedge sys_clk);
      chk({31'h0, general_output_pin}, {31'h0, c[0] ^ c[1]});
      chk({31'h0, ext_amp_enable_out}, {31'h0, c[2] & ~(c[0] ^ c[1])});
      chk({29'h0, output_power_level_field}, {29'h0, c[2:0]});
    end
    $display("outputs done");
  endtask
  // receive cycle: stage timing, serial words, strength readout
  task automatic t_rx();
    apb(1'b1, IDX_R4, 32'h40);
    apb(1'b1, IDX_R9, 32'h100);
    apb(1'b1, IDX_MODE, 32'h0);
    demodSample <= 6'h2b;
    strengthCode <= 4'ha;
    radio_cycle_enable_pin <= 1'b1;
    waitFor(1, 1'b1, 300, a);
    chk({31'h0, a >= 251 && a <= 255}, 32'h1);
    chk({31'h0, filterEnable}, 32'h1);
    chk({31'h0, filterCalRefEnable}, 32'h1);
    chk({30'h0, mixerEnable, lnaEnable}, 32'h0);
    waitFor(2, 1'b1, 3300, a);
    chk(a, 3250);
    chk({31'h0, filterCalRefEnable}, 32'h0);
    waitFor(3, 1'b1, 300, a);
    chk(a, 250);
    chk({31'h0, lnaEnable}, 32'h1);
    repeat (800) @(negedge sys_clk);
    chk({26'h0, lastWord}, 32'h2b);
    chk({31'h0, wordCount >= 16'd85 && wordCount <= 16'd89}, 32'h1);
    @(posedge sys_clk);
    radio_cycle_enable_pin <= 1'b0;
    waitFor(3, 1'b0, 6, a);
    chk({29'h0, lnaEnable, post_mixer_gain_stage, filterEnable}, 32'h0);
    apb(1'b0, IDX_R29, 32'h0);
    chk(rd, 32'ha);
    apb(1'b1, IDX_R9, 32'h0);
    apb(1'b0, IDX_R29, 32'h0);
    chk(rd, 32'h0);
    $display("receive done");
  endtask
  // transmit cycle: trim first, power stage, ramp up and down
  task automatic t_tx();
    apb(1'b1, IDX_R3, 32'h0);
    apb(1'b1, IDX_R2, 32'h100);
    apb(1'b1, IDX_R11, 32'h40);
    apb(1'b1, IDX_MODE, 32'h1);
    radio_cycle_enable_pin <= 1'b1;
    waitFor(4, 1'b1, 8, a);
    chk({31'h0, low_power_output_stage}, 32'h0);
    waitFor(5, 1'b1, 1100, a);
    chk({31'h0, a >= 999 && a <= 1001}, 32'h1);
    chk({30'h0, vcoTrimActive, lnaEnable}, 32'h0);
    chk({31'h0, ext_amp_enable_out}, 32'h1);
    repeat (500) @(negedge sys_clk);
    rampHold = rampLevel;
    repeat (20) @(negedge sys_clk);
    chk({24'h0, rampLevel}, {24'h0, rampHold});
    chk({24'h0, rampHold}, 32'hff);
    @(posedge sys_clk);
    radio_cycle_enable_pin <= 1'b0;
    waitFor(5, 1'b0, 600, a);
    chk({24'h0, rampLevel}, 32'h0);
    $display("transmit done");
  endtask
  // inputs set at time zero, reset held ten cycles
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    radio_cycle_enable_pin = 1'b0;
    demodSample = 6'h00;
    strengthCode = 4'h0;
    numErrors = 0;
    checked = 0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_outputs();
    t_rx();
    t_tx();
    wrap_up();
  end
endmodule
`default_nettype wire
